// ### hdl/csrc_defines.svh
// Register indices, field positions, reset values and codes of the routing block
`ifndef CSRC_DEFINES_SVH
`define CSRC_DEFINES_SVH

// Register indices (byte address is four times the index)
`define CSRC_IDX_PLL_CTRL 10'h010
`define CSRC_IDX_PREDIV   10'h1e0
`define CSRC_IDX_SRC_SEL  10'h1e1
`define CSRC_IDX_UPDATE   10'h232
`define CSRC_IDX_ACTIVE   10'h233

// Reset values of the configuration registers and of the division output
`define CSRC_RST_PLL_CTRL 8'h01
`define CSRC_RST_PREDIV   8'h02
`define CSRC_RST_SRC_SEL  8'h00
`define CSRC_RST_DIST_DIV 3'h4

// Field positions
`define CSRC_MODE_MSB   1
`define CSRC_MODE_LSB   0
`define CSRC_POL_BIT    7
`define CSRC_RATIO_MSB  2
`define CSRC_BYPASS_BIT 0
`define CSRC_SRC_BIT    1

// Codes and limits
`define CSRC_UPDATE_GO    8'h01
`define CSRC_MODE_ON      2'h0
`define CSRC_MODE_PD      2'h1
`define CSRC_RATIO_MIN    3'h2
`define CSRC_RATIO_MAX    3'h6
`define CSRC_CODE_MAX     3'h4
`define CSRC_DIV_NONE     3'h1
`define CSRC_RESP_OKAY    2'h0
`define CSRC_RESP_SLVERR  2'h2
`define CSRC_NUM_REGS     3

`endif

// ### hdl/csrc_pkg.sv
// Types shared by the routing configuration block
package csrc_pkg;
    typedef enum logic [0:0] {
        CSRC_WR_IDLE = 1'b0,
        CSRC_WR_RESP = 1'b1
    } csrc_wr_state_t;

    typedef enum logic [0:0] {
        CSRC_RD_IDLE = 1'b0,
        CSRC_RD_RESP = 1'b1
    } csrc_rd_state_t;
endpackage

// ### hdl/csrc_shadow_reg.sv
// Staging register with an active copy loaded on commit
`timescale 1ns/1ps
module csrc_shadow_reg #(
    parameter int         WIDTH     = 8,
    parameter [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,      // System clock
    input  wire logic             reset_n,  // Async reset, active low
    input  wire logic             wr_en,    // Staging write strobe
    input  wire logic [WIDTH-1:0] wr_data,  // Staging write data
    input  wire logic             commit,   // Copy staging to active
    output logic      [WIDTH-1:0] stage,    // Staged value
    output logic      [WIDTH-1:0] active    // Value in force
);

    // Staged value, written by software
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage <= RESET_VAL;
        end else if (wr_en) begin
            stage <= wr_data;
        end
    end

    // RL15: one-step copy on commit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            active <= RESET_VAL;
        end else if (commit) begin
            active <= stage;
        end
    end

    // Active value only moves on commit
    hold_active_a: assert property ( // RL15
        @(posedge clk) disable iff (!reset_n)
        !commit |=> active == $past(active))
        else $error("active value changed without commit");

    load_active_a: assert property ( // RL15
        @(posedge clk) disable iff (!reset_n)
        commit |=> active == $past(stage))
        else $error("commit did not load staged value");

endmodule

// ### hdl/csrc_config_top.sv
// Clock source routing configuration with AXI4-Lite register access
//
// Notes on behaviour
// RL1: Reset sets PLL power mode to asynchronous power-down, PLL off.
// RL2: Reset sets pre-distribution divider code for divide by four.
// RL3: Bypass bit zero routes source through the pre-distribution divider.
// RL4: Source bit zero selects the external clock input, not the oscillator.
// RL5: Through the divider, division ahead of channel dividers is at least two.
// RL6: Software writes one to the update register to make settings active.
// RL7: Power mode code zero puts the PLL in normal operation.
// RL8: PLL on with external input selected keeps internal oscillator off.
// RL9: PLL on with external input feeds that input to the prescaler.
// RL10: Polarity bit zero positive, one negative phase detector polarity.
// RL11: Reset restores mode, divider, bypass and source defaults.
// RL12: Software keeps channel divider input frequency within its maximum.
// RL13: Divider code supports ratios two, three, four, five and six.
// RL14: Bypass bit one routes source straight to distribution.
// RL15: Writes are staged, then copied to active registers in one step.
`timescale 1ns/1ps
`include "csrc_defines.svh"
module csrc_config_top
    import csrc_pkg::*;
(
    input  wire logic        clk,                  // 10 MHz system clock
    input  wire logic        reset_n,              // Async reset, active low
    input  wire logic [11:0] s_axi_awaddr,         // Write address
    input  wire logic        s_axi_awvalid,        // Write address valid
    output logic             s_axi_awready,        // Write address ready
    input  wire logic [31:0] s_axi_wdata,          // Write data
    input  wire logic [3:0]  s_axi_wstrb,          // Write byte strobes
    input  wire logic        s_axi_wvalid,         // Write data valid
    output logic             s_axi_wready,         // Write data ready
    output logic [1:0]       s_axi_bresp,          // Write response
    output logic             s_axi_bvalid,         // Write response valid
    input  wire logic        s_axi_bready,         // Write response ready
    input  wire logic [11:0] s_axi_araddr,         // Read address
    input  wire logic        s_axi_arvalid,        // Read address valid
    output logic             s_axi_arready,        // Read address ready
    output logic [31:0]      s_axi_rdata,          // Read data
    output logic [1:0]       s_axi_rresp,          // Read response
    output logic             s_axi_rvalid,         // Read data valid
    input  wire logic        s_axi_rready,         // Read data ready
    output logic [1:0]       pll_mode,             // Active PLL power mode
    output logic             pll_on,               // PLL powered on
    output logic             pfd_pol_neg,          // Negative PFD polarity
    output logic [2:0]       prediv_code,          // Active divider code
    output logic             div_bypass,           // Divider bypassed
    output logic             src_osc_sel,          // Internal oscillator source
    output logic             osc_enable,           // Internal oscillator powered
    output logic             prescaler_from_clkin, // Clock input to prescaler
    output logic             predivider_in_path,   // Divider in distribution path
    output logic [2:0]       dist_div              // Division ahead of channels
);

    // Per-entry register indices and reset values
    localparam logic [9:0] REG_IDX [`CSRC_NUM_REGS] = '{
        `CSRC_IDX_PLL_CTRL, `CSRC_IDX_PREDIV, `CSRC_IDX_SRC_SEL};
    // RL1: PLL powered down
    // RL2: divide by four
    // RL11: defaults on reset
    localparam logic [7:0] REG_RST [`CSRC_NUM_REGS] = '{
        `CSRC_RST_PLL_CTRL, `CSRC_RST_PREDIV, `CSRC_RST_SRC_SEL};

    csrc_wr_state_t wr_state;
    csrc_rd_state_t rd_state;
    logic           aw_held;
    logic           w_held;
    logic [9:0]     wr_idx;
    logic [7:0]     wr_byte;
    logic           wr_lane0;
    logic           do_write;
    logic           wr_hit;
    logic           commit;
    logic [9:0]     rd_idx;
    logic [31:0]    next_rdata;
    logic [1:0]     next_rresp;
    logic [7:0]     stage  [`CSRC_NUM_REGS];
    logic [7:0]     active [`CSRC_NUM_REGS];
    logic [2:0]     next_ratio;
    logic           commit_seen;

    // Handshake outputs
    assign s_axi_awready = (wr_state == CSRC_WR_IDLE) && !aw_held;
    assign s_axi_wready  = (wr_state == CSRC_WR_IDLE) && !w_held;
    assign s_axi_bvalid  = (wr_state == CSRC_WR_RESP);
    assign s_axi_arready = (rd_state == CSRC_RD_IDLE);
    assign s_axi_rvalid  = (rd_state == CSRC_RD_RESP);

    // Write performed once both address and data are held
    assign do_write = (wr_state == CSRC_WR_IDLE) && aw_held && w_held;
    assign wr_hit   = (wr_idx == `CSRC_IDX_PLL_CTRL) ||
                      (wr_idx == `CSRC_IDX_PREDIV) ||
                      (wr_idx == `CSRC_IDX_SRC_SEL) ||
                      (wr_idx == `CSRC_IDX_UPDATE);

    // RL6: update register written with one
    assign commit = do_write && wr_lane0 && (wr_idx == `CSRC_IDX_UPDATE) &&
                    (wr_byte == `CSRC_UPDATE_GO);

    // Write address capture
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            wr_idx  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_idx  <= s_axi_awaddr[11:2];
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    // Write data capture, low byte lane only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            w_held   <= 1'b0;
            wr_byte  <= '0;
            wr_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held   <= 1'b1;
            wr_byte  <= s_axi_wdata[7:0];
            wr_lane0 <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // Write response sequencing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_state    <= CSRC_WR_IDLE;
            s_axi_bresp <= `CSRC_RESP_OKAY;
        end else begin
            unique case (wr_state)
                CSRC_WR_IDLE: begin
                    if (do_write) begin
                        wr_state    <= CSRC_WR_RESP;
                        s_axi_bresp <= wr_hit ? `CSRC_RESP_OKAY : `CSRC_RESP_SLVERR;
                    end
                end
                CSRC_WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state <= CSRC_WR_IDLE;
                    end
                end
            endcase
        end
    end

    // RL15: staged and active copies per register
    generate
        for (genvar i = 0; i < `CSRC_NUM_REGS; i++) begin : g_reg
            csrc_shadow_reg #(
                .WIDTH     (8),
                .RESET_VAL (REG_RST[i])
            ) u_shadow (
                .clk     (clk),
                .reset_n (reset_n),
                .wr_en   (do_write && wr_lane0 && (wr_idx == REG_IDX[i])),
                .wr_data (wr_byte),
                .commit  (commit),
                .stage   (stage[i]),
                .active  (active[i])
            );
        end
    endgenerate

    // Read data selection
    assign rd_idx = s_axi_araddr[11:2];
    always_comb begin
        next_rdata = '0;
        next_rresp = `CSRC_RESP_OKAY;
        unique case (rd_idx)
            `CSRC_IDX_PLL_CTRL: next_rdata[7:0] = stage[0];
            `CSRC_IDX_PREDIV:   next_rdata[7:0] = stage[1];
            `CSRC_IDX_SRC_SEL:  next_rdata[7:0] = stage[2];
            `CSRC_IDX_UPDATE:   next_rdata[7:0] = 8'h00;
            `CSRC_IDX_ACTIVE: begin
                next_rdata[7:0]   = active[0];
                next_rdata[15:8]  = active[1];
                next_rdata[23:16] = active[2];
            end
            default:            next_rresp = `CSRC_RESP_SLVERR;
        endcase
    end

    // Read sequencing with registered data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_state    <= CSRC_RD_IDLE;
            s_axi_rdata <= '0;
            s_axi_rresp <= `CSRC_RESP_OKAY;
        end else begin
            unique case (rd_state)
                CSRC_RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_state    <= CSRC_RD_RESP;
                        s_axi_rdata <= next_rdata;
                        s_axi_rresp <= next_rresp;
                    end
                end
                CSRC_RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state <= CSRC_RD_IDLE;
                    end
                end
            endcase
        end
    end

    // RL5: ratio never below two
    // RL13: divider code to ratio, codes above the top clamp to six
    always_comb begin
        if (active[1][`CSRC_RATIO_MSB:0] > `CSRC_CODE_MAX) begin
            next_ratio = `CSRC_RATIO_MAX;
        end else begin
            next_ratio = 3'(active[1][`CSRC_RATIO_MSB:0] + `CSRC_RATIO_MIN);
        end
    end

    // RL7: PLL power follows the active mode code
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pll_mode    <= `CSRC_MODE_PD;
            pll_on      <= 1'b0;
            pfd_pol_neg <= 1'b0;
        end else begin
            pll_mode    <= active[0][`CSRC_MODE_MSB:`CSRC_MODE_LSB];
            pll_on      <= active[0][`CSRC_MODE_MSB:`CSRC_MODE_LSB] == `CSRC_MODE_ON;
            // RL10: polarity bit drives detector sense
            pfd_pol_neg <= active[0][`CSRC_POL_BIT];
        end
    end

    // RL3: divider routing and total division
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prediv_code        <= 3'(`CSRC_RST_PREDIV);
            div_bypass         <= 1'b0;
            predivider_in_path <= 1'b1;
            dist_div           <= `CSRC_RST_DIST_DIV;
        end else begin
            prediv_code        <= active[1][`CSRC_RATIO_MSB:0];
            div_bypass         <= active[2][`CSRC_BYPASS_BIT];
            predivider_in_path <= !active[2][`CSRC_BYPASS_BIT];
            // RL14: bypass gives no division
            dist_div <= active[2][`CSRC_BYPASS_BIT] ? `CSRC_DIV_NONE : next_ratio;
        end
    end

    // RL4: source select and oscillator power
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            src_osc_sel          <= 1'b0;
            osc_enable           <= 1'b0;
            prescaler_from_clkin <= 1'b0;
        end else begin
            src_osc_sel <= active[2][`CSRC_SRC_BIT];
            // RL8: oscillator powered only when selected
            osc_enable  <= active[2][`CSRC_SRC_BIT];
            // RL9: clock input feeds prescaler when PLL on and clock input selected
            prescaler_from_clkin <= !active[2][`CSRC_SRC_BIT] &&
                (active[0][`CSRC_MODE_MSB:`CSRC_MODE_LSB] == `CSRC_MODE_ON);
        end
    end

    // Marks the first commit since reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            commit_seen <= 1'b0;
        end else if (commit) begin
            commit_seen <= 1'b1;
        end
    end

    // Commit followed by outputs two edges later
    sequence commit_seq;
        commit;
    endsequence

    sequence out_follow_seq;
        ##2 (pll_mode == $past(stage[0][`CSRC_MODE_MSB:`CSRC_MODE_LSB], 2)) &&
            (div_bypass == $past(stage[2][`CSRC_BYPASS_BIT], 2)) &&
            (src_osc_sel == $past(stage[2][`CSRC_SRC_BIT], 2));
    endsequence

    commit_apply_a: assert property ( // RL15
        @(posedge clk) disable iff (!reset_n)
        commit_seq |-> out_follow_seq)
        else $error("commit did not reach outputs in two cycles");

    reset_mode_a: assert property ( // RL1
        @(posedge clk) disable iff (!reset_n)
        !commit_seen |-> (pll_mode == `CSRC_MODE_PD) && !pll_on)
        else $error("PLL not powered down by default");

    reset_ratio_a: assert property ( // RL2
        @(posedge clk) disable iff (!reset_n)
        !commit_seen |-> prediv_code == 3'(`CSRC_RST_PREDIV) && dist_div == `CSRC_RST_DIST_DIV)
        else $error("default division is not four");

    reset_route_a: assert property ( // RL11
        @(posedge clk) disable iff (!reset_n)
        !commit_seen |-> !div_bypass && !src_osc_sel && predivider_in_path)
        else $error("default routing not restored");

    min_div_a: assert property ( // RL5
        @(posedge clk) disable iff (!reset_n)
        predivider_in_path |-> dist_div >= `CSRC_RATIO_MIN)
        else $error("divider path divides by less than two");

    route_div_a: assert property ( // RL3
        @(posedge clk) disable iff (!reset_n)
        !div_bypass |-> predivider_in_path &&
            ((prediv_code > `CSRC_CODE_MAX) ? (dist_div == `CSRC_RATIO_MAX) :
                (dist_div == 3'(prediv_code + `CSRC_RATIO_MIN))))
        else $error("divider path ratio wrong");

    bypass_div_a: assert property ( // RL14
        @(posedge clk) disable iff (!reset_n)
        div_bypass |-> !predivider_in_path && dist_div == `CSRC_DIV_NONE)
        else $error("bypass still divides");

    pll_on_a: assert property ( // RL7
        @(posedge clk) disable iff (!reset_n)
        pll_on == (pll_mode == `CSRC_MODE_ON))
        else $error("PLL power disagrees with mode");

    osc_off_a: assert property ( // RL8
        @(posedge clk) disable iff (!reset_n)
        pll_on && !src_osc_sel |-> !osc_enable)
        else $error("oscillator powered while unused");

    prescaler_feed_a: assert property ( // RL9
        @(posedge clk) disable iff (!reset_n)
        pll_on && !src_osc_sel |-> prescaler_from_clkin)
        else $error("clock input not fed to prescaler");

    pol_follow_a: assert property ( // RL10
        @(posedge clk) disable iff (!reset_n)
        commit_seq |-> ##2 pfd_pol_neg == $past(stage[0][`CSRC_POL_BIT], 2))
        else $error("polarity did not follow committed bit");

    // Write answer timing
    write_resp_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        do_write |=> s_axi_bvalid [*1] ##0 (s_axi_bresp == $past(
            wr_hit ? `CSRC_RESP_OKAY : `CSRC_RESP_SLVERR)))
        else $error("write response missing or wrong");

    read_resp_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle after address");

endmodule

// ### tb/tb_top.sv
// Self-checking bench for the clock routing configuration block
`timescale 1ns/1ps
`include "csrc_defines.svh"
module tb_top
    import csrc_pkg::*;
;
    typedef struct packed {
        logic [7:0]  pll;
        logic [7:0]  prdv;
        logic [7:0]  src;
        logic [14:0] exp;
    } csrc_tb_row_t;

    localparam logic [11:0] A_PLL = {`CSRC_IDX_PLL_CTRL, 2'h0};
    localparam logic [11:0] A_DIV = {`CSRC_IDX_PREDIV, 2'h0};
    localparam logic [11:0] A_SRC = {`CSRC_IDX_SRC_SEL, 2'h0};
    localparam logic [11:0] A_UPD = {`CSRC_IDX_UPDATE, 2'h0};
    localparam logic [11:0] A_ACT = {`CSRC_IDX_ACTIVE, 2'h0};
    localparam logic [11:0] A_BAD = 12'h004;
    localparam logic [14:0] OUT_RST = 15'h220c;

    logic        clk, reset_n;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  pll_mode;
    logic [2:0]  prediv_code, dist_div;
    logic        pll_on, pfd_pol_neg, div_bypass, src_osc_sel, osc_enable;
    logic        prescaler_from_clkin, predivider_in_path;
    logic [14:0] outs, prev;
    int          n_fail, total_checks;

    // Ordinary configurations: staged values and the outputs they give
    // rows keep divider input legal
    csrc_tb_row_t rows [6] = '{
        {8'h00, 8'h00, 8'h00, 15'h101a},
        {8'h80, 8'h01, 8'h02, 15'h196b},
        {8'h01, 8'h03, 8'h01, 15'h2381},
        {8'h81, 8'h04, 8'h02, 15'h2c6e},
        {8'h00, 8'h07, 8'h00, 15'h171e},
        {8'h00, 8'h03, 8'h00, 15'h131d}
    };

    // All routing outputs in one word
    assign outs = {pll_mode, pll_on, pfd_pol_neg, prediv_code, div_bypass, src_osc_sel,
                   osc_enable, prescaler_from_clkin, predivider_in_path, dist_div};

    csrc_config_top dut (
        .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pll_mode, .pll_on, .pfd_pol_neg,
        .prediv_code, .div_bypass, .src_osc_sel, .osc_enable, .prescaler_from_clkin,
        .predivider_in_path, .dist_div
    );

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic flag_err(input string msg);
        n_fail++;
        $display("ERROR at %0t: %s", $time, msg);
    endtask

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) flag_err($sformatf("data %h expected %h", got, exp));
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) flag_err($sformatf("response %h expected %h", got, exp));
    endtask

    // Outputs are looked at mid-cycle, where they are settled
    task automatic chk_out(input logic [14:0] exp);
        @(negedge clk);
        total_checks++;
        if (outs !== exp) flag_err($sformatf("outputs %h expected %h", outs, exp));
        @(posedge clk);
    endtask

    // Write: address and data offered together, each released once taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        int   i;
        logic aw_hs, w_hs, b_hs;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        r = 2'h3;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs  = s_axi_wvalid && s_axi_wready;
            b_hs  = s_axi_bvalid === 1'b1;
            r     = s_axi_bresp;
            @(posedge clk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            if (b_hs) break;
        end
        s_axi_bready <= 1'b0;
        if (i == 40) begin
            flag_err("write timeout");
            end_sim();
        end
        @(posedge clk);
    endtask

    // Read: address held until taken, data taken with rvalid
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int   i;
        logic ar_hs, r_hs;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs  = s_axi_rvalid === 1'b1;
            d     = s_axi_rdata;
            r     = s_axi_rresp;
            @(posedge clk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
            if (r_hs) break;
        end
        s_axi_rready <= 1'b0;
        if (i == 40) begin
            flag_err("read timeout");
            end_sim();
        end
        @(posedge clk);
    endtask

    // Staged defaults and active copy after any reset
    task automatic chk_defaults;
        axi_rd(A_PLL, rd, resp);
        chk_val(rd, 32'h01);
        axi_rd(A_DIV, rd, resp);
        chk_val(rd, 32'h02);
        axi_rd(A_SRC, rd, resp);
        chk_val(rd, 32'h00);
        axi_rd(A_ACT, rd, resp);
        chk_val(rd, 32'h0000_0201);
    endtask

    // Stages all three configuration registers
    task automatic load_cfg(input logic [7:0] p, input logic [7:0] v, input logic [7:0] c);
        axi_wr(A_PLL, {24'h0, p}, 4'hf, resp);
        chk_resp(resp, `CSRC_RESP_OKAY);
        axi_wr(A_DIV, {24'h0, v}, 4'hf, resp);
        chk_resp(resp, `CSRC_RESP_OKAY);
        axi_wr(A_SRC, {24'h0, c}, 4'hf, resp);
        chk_resp(resp, `CSRC_RESP_OKAY);
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        flag_err("global timeout");
        end_sim();
    end

    initial begin
        reset_n = 1'b0;
        s_axi_awaddr = 12'h000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 12'h000;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        n_fail = 0;
        total_checks = 0;
        prev = OUT_RST;
        repeat (2) @(posedge clk);
        chk_out(OUT_RST);
        reset_n <= 1'b1;
        @(posedge clk);
        chk_defaults();
        // Table of ordinary configurations
        foreach (rows[k]) begin
            load_cfg(rows[k].pll, rows[k].prdv, rows[k].src);
            chk_out(prev);
            axi_wr(A_UPD, {24'h0, `CSRC_UPDATE_GO}, 4'h1, resp);
            chk_resp(resp, `CSRC_RESP_OKAY);
            chk_out(rows[k].exp);
            axi_rd(A_PLL, rd, resp);
            chk_val(rd, {24'h0, rows[k].pll});
            axi_rd(A_ACT, rd, resp);
            chk_val(rd, {8'h0, rows[k].src, rows[k].prdv, rows[k].pll});
            prev = rows[k].exp;
        end
        // Update with another value is ignored
        axi_wr(A_PLL, 32'h81, 4'hf, resp);
        axi_wr(A_UPD, 32'h02, 4'h1, resp);
        chk_resp(resp, `CSRC_RESP_OKAY);
        chk_out(prev);
        axi_rd(A_UPD, rd, resp);
        chk_val(rd, 32'h0);
        // Write with byte 0 not enabled has no effect
        axi_wr(A_PLL, 32'h00, 4'h0, resp);
        chk_resp(resp, `CSRC_RESP_OKAY);
        axi_rd(A_PLL, rd, resp);
        chk_val(rd, 32'h81);
        // Unmapped and read-only places
        axi_wr(A_BAD, 32'h5a, 4'hf, resp);
        chk_resp(resp, `CSRC_RESP_SLVERR);
        axi_rd(A_BAD, rd, resp);
        chk_resp(resp, `CSRC_RESP_SLVERR);
        chk_val(rd, 32'h0);
        axi_wr(A_ACT, 32'hff, 4'hf, resp);
        chk_resp(resp, `CSRC_RESP_SLVERR);
        axi_rd(A_ACT, rd, resp);
        chk_val(rd, 32'h0000_0300);
        // Commit with power-down and negative polarity
        axi_wr(A_UPD, 32'h01, 4'h1, resp);
        chk_out(15'h2b0d);
        // Reset in mid-run restores defaults
        reset_n <= 1'b0;
        chk_out(OUT_RST);
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk_defaults();
        end_sim();
    end
endmodule
